// File: mcu_reset_control_defs.vh
// Constants for the reset controller: register offsets, field positions,
// reset values, function codes and delay counts.
// Assumes a 10 MHz pclk and a 32-bit APB with word-aligned registers.
`ifndef MCU_RESET_CONTROL_DEFS_VH
`define MCU_RESET_CONTROL_DEFS_VH

// ************************************************************
// Register map
// ************************************************************
`define PIN_FUNC_OFFSET    12'h000
`define CAUSE_FLAGS_OFFSET 12'h004

// ************************************************************
// Function control codes
// ************************************************************
`define PIN_FUNC_GPO       8'h55
`define PIN_FUNC_RESET_IN  8'hAA
`define PIN_FUNC_POR       8'hAA

// ************************************************************
// Cause flag bit positions
// ************************************************************
`define FLAG_WDOG_CTRL     0
`define FLAG_LOWV_CTRL     1
`define FLAG_LOW_VOLTAGE   2
`define FLAG_CTRL_REG      3
`define CAUSE_FLAGS_POR    4'h0

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS      100
`define SW_RESET_DELAY_NS  2000
`define STARTUP_DELAY_NS   5000
// Least times, rounded up to whole cycles
`define SW_RESET_CYCLES \
  ((`SW_RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_CYCLES \
  ((`STARTUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_CNT_W        8

`endif

// File: mcu_reset_control.v
// Reset controller: merges power-on, shared pin, low-voltage, watchdog and
// control-code resets, times the delays and owns two APB registers.
// Assumes pin and low-voltage inputs are asynchronous; the watchdog and
// control-code requests come as one-cycle pulses on pclk.
//
// What this block does
// - Power-on clears program counter to zero
// - Power-up presets all port registers high
// - Falling shared pin resets in reset mode
// - Pin reset only when control selects it
// - Extra delay after pin returns high
// - Pin reset while running keeps some registers
// - Decode output and reset-input codes
// - Invalid code resets after software delay
// - Power-on loads reset-input code
// - Invalid code reset sets flag bit 3
// - All resets except watchdog restore control
// - Reset-input mode overrides other pin sharing
// - Flags set by hardware, cleared by software
// - Upper four flag bits read zero
// - Low voltage gives full reset
// - Watchdog overflow resets the core
// - Low pin level restarts from address zero
// - Watchdog code reset sets flag bit 0
// - Low-voltage code reset sets flag bit 1
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mcu_reset_control_defs.vh"

module mcu_reset_control
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        shared_pin_in,
  input  wire        gpo_data,
  input  wire        alt_func_oe,
  input  wire        alt_func_out,
  output wire        shared_pin_out,
  output wire        shared_pin_output_enable,
  input  wire        low_voltage_detector,
  input  wire        watchdog_overflow,
  input  wire        wdog_ctrl_reset_req,
  input  wire        lowv_ctrl_reset_req,
  output wire        core_reset_n,
  output wire        full_init
);

  localparam [1:0] ST_RUN  = 2'd0;
  localparam [1:0] ST_HOLD = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  // Delay counts cut to the counter width on purpose
  localparam integer STARTUP_CYC = `STARTUP_CYCLES;
  localparam integer SW_CYC      = `SW_RESET_CYCLES;
  localparam [`DELAY_CNT_W-1:0] STARTUP_LAST =
    STARTUP_CYC[`DELAY_CNT_W-1:0] - 1'b1;
  localparam [`DELAY_CNT_W-1:0] SW_LAST =
    SW_CYC[`DELAY_CNT_W-1:0] - 1'b1;

  reg  [1:0]              state_reg;
  reg  [1:0]              state_next;
  reg  [`DELAY_CNT_W-1:0] cnt_reg;
  reg  [`DELAY_CNT_W-1:0] cnt_next;
  reg  [`DELAY_CNT_W-1:0] sw_cnt_reg;
  reg                     sw_pend_reg;
  reg                     sw_fire;
  reg  [7:0]              pin_func_reg;
  reg  [3:0]              flags_reg;
  reg  [3:0]              flags_next;
  reg                     full_reg;
  reg                     full_next;
  reg                     core_reset_n_reg;
  reg                     pin_meta_reg;
  reg                     pin_sync_reg;
  reg                     pin_prev_reg;
  reg                     lv_meta_reg;
  reg                     lv_sync_reg;
  reg                     pin_out_reg;
  reg                     pin_oe_reg;
  reg                     pready_reg;
  reg                     pslverr_reg;
  reg  [31:0]             prdata_reg;
  reg                     restore_func;
  wire                    mode_reset_in;
  wire                    mode_gpo;
  wire                    code_bad;
  wire                    pin_fall;
  wire                    hold_src;
  wire                    acc;
  wire                    hit_func;
  wire                    hit_flags;
  wire                    wr_done;

  // ************************************************************
  // Input synchronisers
  // ************************************************************

  // Two flops on each asynchronous input, third on the pin only for edge history
  // History flops reset high, the pull-up level: no false fall
  // after reset. Edge logic reads the second and third flops.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      lv_meta_reg  <= 1'b0;
      lv_sync_reg  <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= shared_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      lv_meta_reg  <= low_voltage_detector;
      lv_sync_reg  <= lv_meta_reg;
    end

  // ************************************************************
  // Function code decode
  // ************************************************************

  // Only the two exact codes are valid
  // Any other code is a fault; pin then takes alternate drive
  assign mode_reset_in = (pin_func_reg == `PIN_FUNC_RESET_IN);
  assign mode_gpo      = (pin_func_reg == `PIN_FUNC_GPO);
  assign code_bad      = !mode_reset_in && !mode_gpo;

  // Pin reset sources honoured only in reset-input mode
  assign pin_fall = mode_reset_in && pin_prev_reg &&
                    !pin_sync_reg;
  assign hold_src = (mode_reset_in && !pin_sync_reg) ||
                    lv_sync_reg;

  // ************************************************************
  // Invalid code delay
  // ************************************************************

  // Request latched; rewriting a valid code cannot cancel it
  // Latching only while running stops a held core from queueing
  // a second request; a pending one still times out in reset.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sw_pend_reg <= 1'b0;
      sw_cnt_reg  <= {`DELAY_CNT_W{1'b0}};
    end
    else if (sw_fire)
    begin
      sw_pend_reg <= 1'b0;
      sw_cnt_reg  <= {`DELAY_CNT_W{1'b0}};
    end
    else if (sw_pend_reg)
      sw_cnt_reg <= sw_cnt_reg + 1'b1;
    else if (code_bad && core_reset_n_reg)
      sw_pend_reg <= 1'b1;

  // Fire once the software reset delay has elapsed
  always @*
    sw_fire = sw_pend_reg && (sw_cnt_reg == SW_LAST);

  // ************************************************************
  // Reset sequencer
  // ************************************************************

  // Choose next phase, delay count and kind of reset
  // Low voltage ranks first, then the pin, then latched codes and
  // the watchdog. Low voltage or a low pin seen during the wait re-enters the hold
  // phase, so the start-up count always runs from a quiet input.
  always @*
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    full_next    = full_reg;
    restore_func = 1'b0;
    case (state_reg)
      ST_RUN:
      begin
        if (lv_sync_reg)
        begin
          state_next   = ST_HOLD;
          full_next    = 1'b1;
          restore_func = 1'b1;
        end
        else if (pin_fall)
        begin
          state_next   = ST_HOLD;
          full_next    = 1'b0;
          restore_func = 1'b1;
        end
        else if (sw_fire || wdog_ctrl_reset_req ||
                 lowv_ctrl_reset_req)
        begin
          state_next   = ST_WAIT;
          cnt_next     = {`DELAY_CNT_W{1'b0}};
          full_next    = 1'b1;
          restore_func = 1'b1;
        end
        else if (watchdog_overflow)
        begin
          state_next = ST_WAIT;
          cnt_next   = {`DELAY_CNT_W{1'b0}};
          full_next  = 1'b0;
        end
      end
      ST_HOLD:
      begin
        cnt_next = {`DELAY_CNT_W{1'b0}};
        if (lv_sync_reg)
          full_next = 1'b1;
        if (!hold_src)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (hold_src)
        begin
          state_next = ST_HOLD;
          full_next  = full_reg || lv_sync_reg;
          restore_func = 1'b1;
        end
        else if (cnt_reg == STARTUP_LAST)
          state_next = ST_RUN;
        else
          cnt_next = cnt_reg + 1'b1;
      end
      default:
        state_next = ST_WAIT;
    endcase
  end

  // Power-on starts in the start-up wait as a full reset
  // Core release taken from the next state, so it never glitches
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_reg        <= ST_WAIT;
      cnt_reg          <= {`DELAY_CNT_W{1'b0}};
      full_reg         <= 1'b1;
      core_reset_n_reg <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      cnt_reg          <= cnt_next;
      full_reg         <= full_next;
      // Core held, program counter at zero, until release
      core_reset_n_reg <= (state_next == ST_RUN);
    end

  // ************************************************************
  // APB slave
  // ************************************************************

  assign acc       = psel && penable && !pready_reg;
  assign hit_func  = (paddr == `PIN_FUNC_OFFSET);
  assign hit_flags = (paddr == `CAUSE_FLAGS_OFFSET);
  assign wr_done   = psel && penable && pready_reg && pwrite &&
                     !pslverr_reg;

  // One wait state, then a registered answer
  // Every access takes one wait state: the answer is registered
  // from the first access cycle and stands for one cycle only.
  // A write lands at the edge that completes the transfer.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (acc)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !(hit_func || hit_flags);
      if (hit_func && !pwrite)
        prdata_reg <= {24'h00_0000, pin_func_reg};
      else if (hit_flags && !pwrite)
        prdata_reg <= {28'h000_0000, flags_reg};
      else
        prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end

  // ************************************************************
  // Registers
  // ************************************************************

  // Function control: restored by every reset but the watchdog one
  // A pending invalid-code request is not cleared by this write
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      pin_func_reg <= `PIN_FUNC_POR;
    else if (restore_func)
      pin_func_reg <= `PIN_FUNC_POR;
    else if (wr_done && hit_func)
      pin_func_reg <= pwdata[7:0];

  // Cause flags: software writes zero to clear, a set wins
  // Clear and set in one cycle: the set is applied last and wins
  always @*
  begin
    flags_next = flags_reg;
    if (wr_done && hit_flags)
      flags_next = flags_reg & pwdata[3:0];
    if (state_reg == ST_RUN && sw_fire)
      flags_next[`FLAG_CTRL_REG] = 1'b1;
    if (state_reg == ST_RUN && wdog_ctrl_reset_req)
      flags_next[`FLAG_WDOG_CTRL] = 1'b1;
    if (state_reg == ST_RUN && lowv_ctrl_reset_req)
      flags_next[`FLAG_LOWV_CTRL] = 1'b1;
    if (lv_sync_reg)
      flags_next[`FLAG_LOW_VOLTAGE] = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
    if (!presetn)
      flags_reg <= `CAUSE_FLAGS_POR;
    else
      flags_reg <= flags_next;

  // ************************************************************
  // Shared pin
  // ************************************************************

  // Reset-input mode overrides any alternate function drive
  // Registered drive: the pin follows a code change one cycle late
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_oe_reg  <= 1'b0;
      pin_out_reg <= 1'b0;
    end
    else if (mode_reset_in)
    begin
      pin_oe_reg  <= 1'b0;
      pin_out_reg <= 1'b0;
    end
    else if (mode_gpo)
    begin
      pin_oe_reg  <= 1'b1;
      pin_out_reg <= gpo_data;
    end
    else
    begin
      pin_oe_reg  <= alt_func_oe;
      pin_out_reg <= alt_func_out;
    end

  // ************************************************************
  // Outputs
  // ************************************************************
  // All outputs come straight from flops
  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign shared_pin_out           = pin_out_reg;
  assign shared_pin_output_enable = pin_oe_reg;
  assign core_reset_n             = core_reset_n_reg;
  assign full_init                = full_reg;

endmodule // mcu_reset_control

// File: reset_pin_network.sv
// Model of the external reset network on the shared pin.
// Assumes a pull-up to supply and a switch that can ground the pin.
`timescale 1ns/1ps
module reset_pin_network
(
  input  wire pin_out,
  input  wire pin_oe,
  input  wire pull_low,
  output wire pin_level
);
  // ************************************************************
  // Pin level
  // ************************************************************
  // Block drive wins, else the switch or the pull-up
  assign pin_level = pin_oe ? pin_out : !pull_low;
endmodule // reset_pin_network

// File: mcu_reset_control_asserts.sv
// Port checker for the reset controller.
// Assumes it is bound onto the block and APB holds until pready.
`timescale 1ns/1ps
module mcu_reset_control_asserts
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        shared_pin_in,
  input wire        gpo_data,
  input wire        alt_func_oe,
  input wire        alt_func_out,
  input wire        shared_pin_out,
  input wire        shared_pin_output_enable,
  input wire        low_voltage_detector,
  input wire        watchdog_overflow,
  input wire        wdog_ctrl_reset_req,
  input wire        lowv_ctrl_reset_req,
  input wire        core_reset_n,
  input wire        full_init
);
  // ************************************************************
  // Shadow of the function code
  // ************************************************************
  reg  [7:0] mode_reg;
  reg        low_d_reg;
  wire       wr_ctrl;
  // Completed write to the function code
  assign wr_ctrl = psel && penable && pready && pwrite && !pslverr &&
                   paddr == 12'h000;
  // Track writes and full-reset restores
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg  <= 8'hAA;
      low_d_reg <= 1'b0;
    end
    else
    begin
      low_d_reg <= !core_reset_n;
      if (!core_reset_n && low_d_reg && full_init)
        mode_reg <= 8'hAA;
      else if (wr_ctrl)
        mode_reg <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pin_reset;
    mode_reg == 8'hAA && core_reset_n && $fell(shared_pin_in)
    |-> ##[1:5] !core_reset_n ##[0:2] !full_init;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset missing");
  property p_oe_gpo;
    core_reset_n && $past(core_reset_n) && mode_reg == 8'h55 &&
    $past(mode_reg) == 8'h55
    |-> shared_pin_output_enable && shared_pin_out == $past(gpo_data);
  endproperty
  a_oe_gpo: assert property (p_oe_gpo)
    else $error("output mode not driving");
  property p_oe_rst;
    core_reset_n && mode_reg == 8'hAA && $past(mode_reg) == 8'hAA
    |-> !shared_pin_output_enable;
  endproperty
  a_oe_rst: assert property (p_oe_rst)
    else $error("reset input mode drives pin");
  property p_sw_delay;
    wr_ctrl && pwdata[7:0] != 8'h55 && pwdata[7:0] != 8'hAA && core_reset_n
    |-> core_reset_n [*8] ##[12:16] !core_reset_n;
  endproperty
  a_sw_delay: assert property (p_sw_delay)
    else $error("invalid code reset mistimed");
  property p_upper;
    psel && penable && pready && !pwrite
    |-> prdata[31:8] == 24'h0 && (paddr != 12'h004 || prdata[7:4] == 4'h0);
  endproperty
  a_upper: assert property (p_upper)
    else $error("unused read bits set");
  property p_release;
    $rose(core_reset_n) |-> !$past(core_reset_n, 48);
  endproperty
  a_release: assert property (p_release)
    else $error("reset released early");
  property p_lv;
    $rose(low_voltage_detector) && core_reset_n
    |-> ##[1:4] !core_reset_n ##[0:2] full_init;
  endproperty
  a_lv: assert property (p_lv)
    else $error("low voltage reset missing");
  property p_wdog;
    watchdog_overflow && core_reset_n
    |-> ##[1:2] !core_reset_n ##[0:2] !full_init;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog reset missing");
  c_pin: cover property (mode_reg == 8'hAA && core_reset_n &&
                         $fell(shared_pin_in));
  c_sw: cover property ($fell(core_reset_n) && mode_reg == 8'hAA);
  c_wdog: cover property (watchdog_overflow && core_reset_n);
endmodule // mcu_reset_control_asserts
bind mcu_reset_control mcu_reset_control_asserts mcu_reset_control_asserts_inst
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .shared_pin_in, .gpo_data, .alt_func_oe, .alt_func_out,
  .shared_pin_out, .shared_pin_output_enable, .low_voltage_detector,
  .watchdog_overflow, .wdog_ctrl_reset_req, .lowv_ctrl_reset_req,
  .core_reset_n, .full_init
);

// File: mcu_reset_control_tb_top.sv
// Self-checking bench for the reset controller.
// Assumes the defs header on the include path and a 10 MHz pclk.
`timescale 1ns/1ps
`include "mcu_reset_control_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module mcu_reset_control_tb_top;
  reg         pclk, presetn, psel, penable, pwrite, gpo_data, pull_low;
  reg         alt_func_oe, alt_func_out, low_voltage_detector;
  reg         watchdog_overflow, wdog_ctrl_reset_req, lowv_ctrl_reset_req;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg         e;
  wire [31:0] prdata;
  wire        pready, pslverr, shared_pin_in, shared_pin_out;
  wire        shared_pin_output_enable, core_reset_n, full_init;
  int         error_cnt, n_checks, n;
  // ************************************************************
  // Block, pin network and clock
  // ************************************************************
  mcu_reset_control mcu_reset_control_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .shared_pin_in, .gpo_data, .alt_func_oe, .alt_func_out, .shared_pin_out,
    .shared_pin_output_enable, .low_voltage_detector, .watchdog_overflow,
    .wdog_ctrl_reset_req, .lowv_ctrl_reset_req, .core_reset_n, .full_init);
  reset_pin_network reset_pin_network_inst (.pin_out(shared_pin_out),
    .pin_oe(shared_pin_output_enable), .pull_low, .pin_level(shared_pin_in));
  // Clock of 100 ns
  always #50 pclk = ~pclk;
  task complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wait_core(input reg v, input int lim);
    n = 0;
    while (core_reset_n !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (core_reset_n !== v)
    begin
      error_cnt++;
      complete_run();
    end
  endtask
  task t_por;
    `CHK({core_reset_n, full_init}, 2'b01)
    wait_core(1'b1, 200);
    `CHK(n > `STARTUP_CYCLES - 3, 1'b1)
    `CHK(shared_pin_output_enable, 1'b0)
    apb(1'b0, `PIN_FUNC_OFFSET, 32'h0000_0000);
    `CHK(q, 32'h0000_00AA)
    apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    `CHK(q & 32'hFFFF_FFFB, 32'h0000_0000)
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    $display("power-on test done");
  endtask
  task t_gpo;
    apb(1'b1, `PIN_FUNC_OFFSET, 32'h0000_0055);
    gpo_data <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK({shared_pin_output_enable, shared_pin_out}, 2'b11)
    gpo_data <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK({core_reset_n, shared_pin_out}, 2'b10)
    $display("output mode test done");
  endtask
  task t_invalid;
    apb(1'b1, `PIN_FUNC_OFFSET, 32'h0000_003C);
    repeat (2) @(posedge pclk);
    `CHK({shared_pin_output_enable, shared_pin_out}, 2'b11)
    apb(1'b1, `PIN_FUNC_OFFSET, 32'h0000_00AA);
    wait_core(1'b0, 40);
    `CHK(n > 15 && n < 22, 1'b1)
    repeat (2) @(posedge pclk);
    `CHK(full_init, 1'b1)
    wait_core(1'b1, 200);
    apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    `CHK(q[3], 1'b1)
    apb(1'b0, `PIN_FUNC_OFFSET, 32'h0000_0000);
    `CHK(q, 32'h0000_00AA)
    $display("invalid code test done");
  endtask
  task t_pin;
    repeat (3) @(posedge pclk);
    `CHK(shared_pin_output_enable, 1'b0)
    pull_low <= 1'b1;
    wait_core(1'b0, 8);
    `CHK(n < 6, 1'b1)
    repeat (3) @(posedge pclk);
    `CHK(full_init, 1'b0)
    repeat (10) @(posedge pclk);
    pull_low <= 1'b0;
    wait_core(1'b1, 200);
    `CHK(n >= `STARTUP_CYCLES, 1'b1)
    apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    `CHK(q[3], 1'b1)
    $display("pin reset test done");
  endtask
  task t_wdog;
    apb(1'b1, `PIN_FUNC_OFFSET, 32'h0000_0055);
    watchdog_overflow <= 1'b1;
    @(posedge pclk);
    watchdog_overflow <= 1'b0;
    wait_core(1'b0, 4);
    repeat (3) @(posedge pclk);
    `CHK(full_init, 1'b0)
    wait_core(1'b1, 200);
    apb(1'b0, `PIN_FUNC_OFFSET, 32'h0000_0000);
    `CHK(q, 32'h0000_0055)
    $display("watchdog test done");
  endtask
  task t_codes;
    for (int i = 0; i < 3; i++)
    begin
      {low_voltage_detector, lowv_ctrl_reset_req, wdog_ctrl_reset_req}
        <= 3'b001 << i;
      @(posedge pclk);
      {lowv_ctrl_reset_req, wdog_ctrl_reset_req} <= 2'b00;
      wait_core(1'b0, 6);
      repeat (3) @(posedge pclk);
      low_voltage_detector <= 1'b0;
      `CHK(full_init, 1'b1)
      wait_core(1'b1, 200);
      apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
      `CHK(q[i], 1'b1)
    end
    apb(1'b1, `CAUSE_FLAGS_OFFSET, 32'h0000_00FF);
    apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    `CHK(q, 32'h0000_000F)
    apb(1'b1, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    apb(1'b0, `CAUSE_FLAGS_OFFSET, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    $display("flag test done");
  endtask
  // Main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, gpo_data, pull_low} = 7'h00;
    {alt_func_oe, alt_func_out, low_voltage_detector} = 3'b110;
    {watchdog_overflow, wdog_ctrl_reset_req, lowv_ctrl_reset_req} = 3'b000;
    {paddr, pwdata} = 44'h000_0000_0000;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_por();
    t_gpo();
    t_invalid();
    t_pin();
    t_wdog();
    t_codes();
    complete_run();
  end
endmodule // mcu_reset_control_tb_top
